// ### bench/vpp_codec_model.sv
// far-side codec model: link clock, frame sync, serial data
module vpp_codec_model (
   input wire logic go_i,
   input wire logic short_i,
   input wire logic [63:0] din_word_i,
   input wire logic dout_i,
   input wire logic dout_oe_i,
   output logic bclk_o,
   output logic sync_o,
   output logic din_o,
   output logic busy_o,
   output logic [63:0] dout_word_o,
   output logic [63:0] oe_word_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************************************
   // frame generator
   // ****************************************************************
   // link clock stands low between frames
   initial begin
      {bclk_o, sync_o, din_o, busy_o} = 4'h0;
      dout_word_o = 64'h0;
      oe_word_o = 64'h0;
   end
   // one frame of 64 bits on a 400 ns bit clock
   always @(posedge go_i) begin
      busy_o = 1'b1;
      if (short_i) begin
         {bclk_o, sync_o} = 2'h3;
         #200 bclk_o = 1'b0;
         #200;
      end
      for (int k = 0; k < 64; k++) begin
         bclk_o = 1'b1;
         sync_o = !short_i && k < 8;
         din_o = din_word_i[63-k];
         #200 bclk_o = 1'b0;
         // a released line shows the inverse of the level left on it
         dout_word_o[63-k] = dout_oe_i ? dout_i : !dout_i;
         oe_word_o[63-k] = dout_oe_i;
         #200;
      end
      // released line must not keep its last level
      din_o = !din_o;
      busy_o = 1'b0;
   end
endmodule // vpp_codec_model

// ### bench/vpp_core_tb_top.sv
// testbench top for the voice port core
module vpp_core_tb_top import vpp_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_i = 1'b0;
   logic nrst_i = 1'b0;
   vpp_cfg_t cfg = CFG_RESET;
   logic bclk, sync, din, go = 1'b0, short_sel = 1'b0, busy;
   logic [63:0] din_word = 64'h0, dout_word, oe_word;
   logic [3:0][15:0] tx = 64'h0;
   logic rx_ready = 1'b0, ov_clr = 1'b0;
   logic bclk_o, bclk_oe, sync_o, sync_oe, dout, dout_oe, rx_valid, rx_overrun;
   vpp_rx_t rx_data;
   int bad_count = 0, comparisons = 0;
   int takes = 0; // sample take pulses seen
   logic take;
   // ****************************************************************
   // clock, instances, checking
   // ****************************************************************
   always #25 clk_sys_i = !clk_sys_i;
   // one take pulse per frame start
   always @(posedge clk_sys_i) if (take) takes++;
   vpp_core u_vpp_core (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
      .voice_port_config_word_i(cfg), .bclk_i(bclk), .bclk_o(bclk_o),
      .bclk_oe_o(bclk_oe), .sync_i(sync), .sync_o(sync_o), .sync_oe_o(sync_oe),
      .din_i(din), .dout_o(dout), .dout_oe_o(dout_oe), .tx_sample_i(tx),
      .tx_take_o(take), .rx_valid_o(rx_valid), .rx_ready_i(rx_ready),
      .rx_data_o(rx_data), .rx_overrun_o(rx_overrun), .rx_overrun_clr_i(ov_clr));
   vpp_codec_model u_vpp_codec_model (.go_i(go), .short_i(short_sel),
      .din_word_i(din_word), .dout_i(dout), .dout_oe_i(dout_oe), .bclk_o(bclk),
      .sync_o(sync), .din_o(din), .busy_o(busy), .dout_word_o(dout_word),
      .oe_word_o(oe_word));
   task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic give_verdict();
      if (bad_count == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // link config from the reset word; enum fields set by name, never from bare bits
   function automatic vpp_cfg_t mk(logic [3:0] en, vpp_frame_t fr, vpp_fmt_t f, logic lit,
      logic s16);
      vpp_cfg_t c;
      c = vpp_cfg_t'(CFG_RESET);
      c.slot_en = en;
      c.frame = fr;
      c.fmt = f;
      c.little = lit;
      c.slot16 = s16;
      return c;
   endfunction
   // config change, then one codec frame plus pipeline drain
   task automatic frame(vpp_cfg_t c);
      @(negedge clk_sys_i) cfg = c;
      repeat (3) @(negedge clk_sys_i);
      go = 1'b1;
      @(negedge clk_sys_i) go = 1'b0;
      for (int i = 0; i < 900 && busy; i++) @(negedge clk_sys_i);
      repeat (10) @(negedge clk_sys_i);
   endtask
   // take one received word, bounded wait
   task automatic pop(logic [17:0] exp);
      for (int i = 0; i < 50 && !rx_valid; i++) @(negedge clk_sys_i);
      check("rx_data", rx_data, exp);
      rx_ready = 1'b1;
      @(negedge clk_sys_i) rx_ready = 1'b0;
      @(negedge clk_sys_i);
   endtask
   // ****************************************************************
   // scenarios
   // ****************************************************************
   // slave GCI frame, B1 only: the slot 2 enable is ignored
   task automatic t_long();
      tx[0] = 16'hA5C3;
      din_word = {16'h1234, 48'h0};
      frame(mk(4'h5, VPP_GCI, VPP_LIN16, 1'b0, 1'b1));
      check("dout slot0", dout_word[63:48], 16'hA5C3);
      check("oe", oe_word, 64'hFFFF000000000000);
      check("slave oe", {bclk_oe, sync_oe}, 2'h0);
      check("take", takes, 1);
      pop({2'h0, 16'h1234});
   endtask
   // short sync, little endian 13-bit with attenuation pad, then mute
   task automatic t_short();
      vpp_cfg_t c;
      short_sel = 1'b1;
      c = mk(4'h1, VPP_SFS, VPP_LIN13, 1'b1, 1'b1);
      c.pad = VPP_PAD_ATTEN;
      c.atten = 3'h2;
      frame(c);
      check("little", dout_word[63:48], 16'hC3A2);
      pop({2'h0, 16'h0C48});
      c = mk(4'h1, VPP_SFS, VPP_LIN16, 1'b0, 1'b1);
      c.mute = 1'b1;
      frame(c);
      check("mute", dout_word[63:32], 32'h0000FFFF);
      pop({2'h0, 16'h1234});
      short_sel = 1'b0;
   endtask
   // three 8-clock slots, fifo overfilled then drained
   task automatic t_slots();
      tx = {16'h0, 16'h00C3, 16'h0096, 16'h005A};
      din_word = {24'h112233, 40'h0};
      repeat (4) frame(mk(4'h7, VPP_LFS, VPP_ULAW, 1'b0, 1'b0));
      check("slots", dout_word[63:32], 32'h5A96C3FF);
      check("oe8", oe_word[63:32], 32'hFFFFFF00);
      check("overrun", rx_overrun, 1'b1);
      for (int i = 0; i < 9; i++) pop({2'(i % 3), 8'h0, 8'(17 * (i % 3 + 1))});
      check("drained", rx_valid, 1'b0);
      ov_clr = 1'b1;
      @(negedge clk_sys_i) ov_clr = 1'b0;
      @(negedge clk_sys_i) check("ov clr", rx_overrun, 1'b0);
   endtask
   // master clock half period and sync width in system cycles
   task automatic t_master(logic fast, logic l16, int exp_half);
      int n;
      vpp_cfg_t c;
      c = vpp_cfg_t'(CFG_RESET);
      c.master = 1'b1;
      c.rate = RATE_1536;
      c.fast_synth_clock_select = fast;
      c.long16 = l16;
      @(negedge clk_sys_i) cfg = c;
      for (n = 0; n < 5000 && !sync_o; n++) @(negedge clk_sys_i);
      for (n = 0; n < 5000 && sync_o; n++) @(negedge clk_sys_i);
      // sixteen-clock sync only with the fast synthesis clock
      check("sync len", n, 2 * exp_half * ((fast && l16) ? SYNC_LEN_LONG16 : SYNC_LEN_LONG));
      check("master oe", {bclk_oe, sync_oe}, 2'h3);
      for (n = 0; n < 500 && !bclk_o; n++) @(negedge clk_sys_i);
      for (n = 0; n < 500 && bclk_o; n++) @(negedge clk_sys_i);
      check("half", n, exp_half);
   endtask
   // master short sync width, then gated sync stays low for more than a frame
   task automatic t_gate();
      int n;
      @(negedge clk_sys_i) cfg.frame = VPP_SFS;
      for (n = 0; n < 5000 && !sync_o; n++) @(negedge clk_sys_i);
      for (n = 0; n < 5000 && sync_o; n++) @(negedge clk_sys_i);
      check("short len", n, 2 * HALF_512);
      @(negedge clk_sys_i) cfg.sync_gate = 1'b1;
      repeat (4) @(negedge clk_sys_i);
      repeat (3000) @(negedge clk_sys_i) check("gate", sync_o, 1'b0);
   endtask
   initial begin
      repeat (6) @(negedge clk_sys_i);
      nrst_i = 1'b1;
      t_long();
      t_short();
      t_slots();
      t_master(1'b1, 1'b1, HALF_1536);
      t_master(1'b0, 1'b1, HALF_512);
      t_gate();
      give_verdict();
   end
   // watchdog well beyond the expected run
   initial begin
      #2_000_000;
      bad_count++;
      give_verdict();
   end
endmodule // vpp_core_tb_top

// ### rtl/vpp_core.sv
// voice port: serial PCM engine, receive FIFO and top level

// ****************************************************************
// receive FIFO
// ****************************************************************
module vpp_fifo #(
   parameter int unsigned WIDTH = 18,
   parameter int unsigned DEPTH = 8
) (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
   localparam logic [AW-1:0] LASTP = AW'(DEPTH - 1);

   logic [WIDTH-1:0] mem [DEPTH]; // flip-flop storage
   logic [AW-1:0] wr_ptr; // next slot to write
   logic [AW-1:0] rd_ptr; // oldest entry
   logic [AW:0] count; // entries held
   wire push = in_valid_i && in_ready_o;
   wire pop = out_valid_o && out_ready_i;

   assign in_ready_o = (count != FULL);
   assign out_valid_o = (count != '0);
   assign out_data_o = mem[rd_ptr];

   // pointers and fill level
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) wr_ptr <= (wr_ptr == LASTP) ? '0 : wr_ptr + 1'b1;
         if (pop) rd_ptr <= (rd_ptr == LASTP) ? '0 : rd_ptr + 1'b1;
         if (push && !pop) count <= count + 1'b1;
         else if (pop && !push) count <= count - 1'b1;
      end
   end

   // storage write, no reset needed on data
   always_ff @(posedge clk_sys_i) begin
      if (push) mem[wr_ptr] <= in_data_i;
   end
endmodule // vpp_fifo

module vpp_core
   import vpp_pkg::*;
#(
   parameter int unsigned FIFO_DEPTH = 8
) (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic [31:0] voice_port_config_word_i,
   input wire logic bclk_i,
   output logic bclk_o,
   output logic bclk_oe_o,
   input wire logic sync_i,
   output logic sync_o,
   output logic sync_oe_o,
   input wire logic din_i,
   output logic dout_o,
   output logic dout_oe_o,
   input wire logic [3:0][15:0] tx_sample_i,
   output logic tx_take_o,
   output logic rx_valid_o,
   input wire logic rx_ready_i,
   output vpp_rx_t rx_data_o,
   output logic rx_overrun_o,
   input wire logic rx_overrun_clr_i
);

   // ****************************************************************
   // configuration decode
   // ****************************************************************
   vpp_cfg_t cfg; // registered configuration word

   // whole option set comes from one word
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) cfg <= vpp_cfg_t'(CFG_RESET);
      else cfg <= vpp_cfg_t'(voice_port_config_word_i);
   end

   wire is8 = (cfg.fmt == VPP_ULAW) || (cfg.fmt == VPP_ALAW); // companded sample
   wire short_fs = (cfg.frame == VPP_SFS);
   wire gci = (cfg.frame == VPP_GCI);
   // linear samples never fit an 8-clock slot, so widen it
   wire slot16 = cfg.slot16 | ~is8;
   // GCI maps the two B channels to slots 0 and 1
   wire [3:0] gci_en = {2'b00, cfg.slot_en[1:0]};
   // a fourth enable is dropped: only three links exist
   wire [3:0] pcm_en = (&cfg.slot_en) ? {1'b0, cfg.slot_en[2:0]} : cfg.slot_en;
   wire [3:0] slot_en = gci ? gci_en : pcm_en;
   wire [2:0] rate_req = (cfg.rate > RATE_2400) ? RATE_2400 : cfg.rate;
   // slow synthesis cannot reach the fast rates
   wire slow_cap = !cfg.fast_synth_clock_select && (rate_req > RATE_512);
   wire [2:0] rate = slow_cap ? RATE_512 : rate_req;
   wire [6:0] half = (rate == RATE_128) ? HALF_128 :
                     (rate == RATE_256) ? HALF_256 :
                     (rate == RATE_512) ? HALF_512 :
                     (rate == RATE_1536) ? HALF_1536 : HALF_2400;
   wire [8:0] fbits = (rate == RATE_128) ? FBITS_128 :
                      (rate == RATE_256) ? FBITS_256 :
                      (rate == RATE_512) ? FBITS_512 :
                      (rate == RATE_1536) ? FBITS_1536 : FBITS_2400;
   wire long16 = cfg.fast_synth_clock_select && cfg.long16;
   wire [4:0] sync_len = short_fs ? SYNC_LEN_SHORT : long16 ? SYNC_LEN_LONG16 : SYNC_LEN_LONG;
   wire [3:0] slot_last = slot16 ? SLOT16_LAST : SLOT8_LAST;
   wire [5:0] frame_last = slot16 ? FRAME_LAST16 : FRAME_LAST8;

   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   logic [2:0] bclk_s; // bit 0 feeds only bit 1
   logic [2:0] sync_s;
   logic [1:0] din_s;

   // two flops before any logic, third for edge finding
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         bclk_s <= 3'h0;
         sync_s <= 3'h0;
         din_s <= 2'h0;
      end else begin
         bclk_s <= {bclk_s[1:0], bclk_i};
         sync_s <= {sync_s[1:0], sync_i};
         din_s <= {din_s[0], din_i};
      end
   end

   // ****************************************************************
   // master bit clock divider
   // ****************************************************************
   logic [6:0] div_cnt; // cycles left in this half period
   wire tick = (div_cnt == 7'h00);

   // toggles the driven bit clock every half period
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i || !cfg.master) begin
         div_cnt <= 7'h00;
         bclk_o <= 1'b0;
      end else if (tick) begin
         div_cnt <= half - 7'h01;
         bclk_o <= ~bclk_o;
      end else begin
         div_cnt <= div_cnt - 7'h01;
      end
   end

   // edges come from the divider as master, from the pin as slave
   wire rise_ev = cfg.master ? (tick && !bclk_o) : (bclk_s[1] && !bclk_s[2]);
   wire fall_ev = cfg.master ? (tick && bclk_o) : (!bclk_s[1] && bclk_s[2]);

   // ****************************************************************
   // master frame sync
   // ****************************************************************
   logic [8:0] fcnt; // bit clock within the 8 kHz frame
   wire [8:0] fbits_last = fbits - 9'h001;
   wire [8:0] next_fcnt = (fcnt >= fbits_last) ? 9'h000 : fcnt + 9'h001;
   wire long_hi = (next_fcnt < {4'h0, sync_len});
   wire short_hi = (next_fcnt == fbits_last);
   // gating holds sync low while the clock keeps running
   wire next_sync = cfg.sync_gate ? 1'b0 : (short_fs ? short_hi : long_hi);

   // frame counter and sync move on the rising bit clock edge
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i || !cfg.master) begin
         fcnt <= FBITS_128 - 9'h001;
         sync_o <= 1'b0;
      end else if (rise_ev) begin
         fcnt <= next_fcnt;
         sync_o <= next_sync;
      end
   end

   // pin directions follow the role
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         bclk_oe_o <= 1'b0;
         sync_oe_o <= 1'b0;
      end else begin
         bclk_oe_o <= cfg.master;
         sync_oe_o <= cfg.master;
      end
   end

   // ****************************************************************
   // frame start detection
   // ****************************************************************
   logic armed; // short sync seen at the last falling edge
   wire sync_rose = sync_s[1] && !sync_s[2];

   // short sync is caught on a falling edge, word begins next rising
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) armed <= 1'b0;
      else if (fall_ev) armed <= sync_s[1];
      else if (rise_ev) armed <= 1'b0;
   end

   // slave long/GCI: any width of sync works, only its edge counts
   wire slave_start = short_fs ? (rise_ev && armed) : sync_rose;
   wire start = cfg.master ? (rise_ev && next_fcnt == 9'h000) : slave_start;

   // ****************************************************************
   // bit position and slots
   // ****************************************************************
   logic [5:0] pos; // bit clock since frame start
   logic active; // inside the four-slot window

   // position advances on each rising edge until the window ends
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         pos <= 6'h00;
         active <= 1'b0;
      end else if (start) begin
         pos <= 6'h00;
         active <= 1'b1;
      end else if (rise_ev && active) begin
         if (pos == frame_last) active <= 1'b0;
         else pos <= pos + 6'h01;
      end
   end

   // slot n begins n slot lengths after the start
   wire [1:0] slot_idx = slot16 ? pos[5:4] : pos[4:3];
   wire [3:0] bit_idx = slot16 ? pos[3:0] : {1'b0, pos[2:0]};
   wire slot_on = active && slot_en[slot_idx];
   wire last_bit = (bit_idx == slot_last);

   // ****************************************************************
   // transmit path
   // ****************************************************************
   logic [15:0] tx_word [4]; // formatted slot words for this frame
   logic [15:0] fmt_word [4];

   for (genvar s = 0; s < 4; s++) begin : g_slot
      wire [15:0] smp = tx_sample_i[s];
      wire [2:0] pad3 = (cfg.pad == VPP_PAD_SIGN) ? {3{smp[12]}} :
                        (cfg.pad == VPP_PAD_ATTEN) ? cfg.atten : 3'h0;
      wire [7:0] pad8 = (cfg.pad == VPP_PAD_SIGN) ? {8{smp[7]}} :
                        (cfg.pad == VPP_PAD_ATTEN) ? {5'h00, cfg.atten} : 8'h00;
      assign fmt_word[s] = (cfg.fmt == VPP_LIN16) ? smp :
                           (cfg.fmt == VPP_LIN13) ? {pad3, smp[12:0]} :
                           slot16 ? {pad8, smp[7:0]} : {8'h00, smp[7:0]};

      // samples from the voice link are taken once per frame
      always_ff @(posedge clk_sys_i) begin
         if (!nrst_i) tx_word[s] <= 16'h0000;
         else if (start) tx_word[s] <= fmt_word[s];
      end
   end

   wire [15:0] cur_word = tx_word[slot_idx];
   wire [3:0] big_idx = slot_last - bit_idx;
   wire tx_bit = cfg.little ? cur_word[bit_idx] : cur_word[big_idx];

   logic early_off; // output already released in the lsb
   // early release on the lsb falling edge, else at the next rising edge
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) early_off <= 1'b0;
      else if (start || rise_ev) early_off <= 1'b0;
      else if (fall_ev && slot_on && last_bit && !cfg.late_release) early_off <= 1'b1;
   end

   // output follows position, so it changes after rising edges only, except the enable dropping after the lsb falling edge on early release
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         dout_o <= 1'b0;
         dout_oe_o <= 1'b0;
         tx_take_o <= 1'b0;
      end else begin
         dout_o <= slot_on && !cfg.mute && tx_bit;
         dout_oe_o <= slot_on && !early_off;
         tx_take_o <= start;
      end
   end

   // ****************************************************************
   // receive path
   // ****************************************************************
   logic [15:0] rx_sh; // slot bits gathered so far
   wire [15:0] rx_base = (bit_idx == 4'h0) ? 16'h0000 : rx_sh;
   wire [15:0] rx_big = {rx_base[14:0], din_s[1]};
   wire [15:0] rx_lit = rx_base | ({15'h0000, din_s[1]} << bit_idx);
   wire [15:0] next_rx_sh = cfg.little ? rx_lit : rx_big;
   wire [15:0] rx_sample = (cfg.fmt == VPP_LIN16) ? next_rx_sh :
                           (cfg.fmt == VPP_LIN13) ? {{3{next_rx_sh[12]}}, next_rx_sh[12:0]} :
                           {8'h00, next_rx_sh[7:0]};
   wire push = fall_ev && slot_on && last_bit;
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire [$bits(vpp_rx_t)-1:0] fifo_out_data;
   wire load = fifo_out_valid && (!rx_valid_o || rx_ready_i);

   // input is sampled on the falling bit clock edge only
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) rx_sh <= 16'h0000;
      else if (fall_ev && slot_on) rx_sh <= next_rx_sh;
   end

   // received slots go to the voice links through the FIFO
   vpp_fifo #(
      .WIDTH($bits(vpp_rx_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_rx_fifo (
      .clk_sys_i(clk_sys_i),
      .nrst_i(nrst_i),
      .in_valid_i(push),
      .in_ready_o(fifo_in_ready),
      .in_data_i({slot_idx, rx_sample}),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(load),
      .out_data_o(fifo_out_data)
   );

   // registered output stage, stalls the FIFO while the link is busy
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         rx_valid_o <= 1'b0;
         rx_data_o <= '0;
      end else if (load) begin
         rx_valid_o <= 1'b1;
         rx_data_o <= vpp_rx_t'(fifo_out_data);
      end else if (rx_ready_i) begin
         rx_valid_o <= 1'b0;
      end
   end

   // a slot lost to a full FIFO is flagged; a new loss beats the clear
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) rx_overrun_o <= 1'b0;
      else if (push && !fifo_in_ready) rx_overrun_o <= 1'b1;
      else if (rx_overrun_clr_i) rx_overrun_o <= 1'b0;
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   logic [8:0] sh_cnt; // rising edges seen while sync is high
   logic sync_clean; // this sync began at its proper place

   // helper counters for the sync width check
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         sh_cnt <= 9'h000;
         sync_clean <= 1'b0;
      end else if (rise_ev) begin
         sh_cnt <= sync_o ? sh_cnt + 9'h001 : 9'h000;
         if (!sync_o) sync_clean <= short_fs || (next_fcnt == 9'h000);
      end
   end

   AST_ROLE_PINS: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      !cfg.master |=> !bclk_oe_o && !sync_oe_o && !sync_o && !bclk_o)
      else $error("slave role still drives clock or sync");
   AST_MUTE_LOW: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      cfg.mute |=> !dout_o)
      else $error("muted output not low");
   AST_SYNC_GATED: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      cfg.master && cfg.sync_gate && rise_ev |=> !sync_o)
      else $error("gated sync went high");
   AST_SLOW_RATE: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      !cfg.fast_synth_clock_select |-> half >= HALF_512)
      else $error("slow synthesis above 512 kHz");
   AST_LONG_WIDTH: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      $fell(sync_o) && cfg.master && $past(cfg.master) && !$past(cfg.sync_gate)
      && sync_clean && !short_fs |-> sh_cnt == {4'h0, sync_len})
      else $error("long sync width wrong");
   AST_SHORT_ONE: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      $fell(sync_o) && cfg.master && $past(cfg.master) && short_fs |-> sh_cnt == 9'h001)
      else $error("short sync not one bit clock");
   AST_IDLE_SLOT: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      !slot_on |=> !dout_oe_o)
      else $error("output driven outside a selected slot");
   AST_FMT_SLOT: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      cfg.fmt == VPP_LIN13 || cfg.fmt == VPP_LIN16 |-> frame_last == FRAME_LAST16)
      else $error("linear sample in 8-clock slot");
   AST_SLOTS3: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      $countones(slot_en) <= 3)
      else $error("more than three slots enabled");
   AST_RX_FALL: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      !(fall_ev && slot_on) |=> $stable(rx_sh))
      else $error("input sampled off the falling edge");
   AST_EARLY_Z: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      fall_ev && slot_on && last_bit && !cfg.late_release ##1 !rise_ev && !start
      |=> !dout_oe_o)
      else $error("early release missed");

endmodule // vpp_core

// ### rtl/vpp_pkg.sv
// package: voice port constants, configuration layout and data carriers
package vpp_pkg;

   // ****************************************************************
   // clock and rate constants
   // ****************************************************************
   localparam int unsigned CLK_HZ = 20_000_000; // system clock rate
   localparam int unsigned FS_HZ = 8_000; // frame (sample) rate
   localparam int unsigned BCLK_128_HZ = 128_000; // master bit clock choices
   localparam int unsigned BCLK_256_HZ = 256_000;
   localparam int unsigned BCLK_512_HZ = 512_000;
   localparam int unsigned BCLK_1536_HZ = 1_536_000;
   localparam int unsigned BCLK_2400_HZ = 2_400_000;

   // rate select codes in the configuration word
   localparam logic [2:0] RATE_128 = 3'h0;
   localparam logic [2:0] RATE_256 = 3'h1;
   localparam logic [2:0] RATE_512 = 3'h2;
   localparam logic [2:0] RATE_1536 = 3'h3;
   localparam logic [2:0] RATE_2400 = 3'h4;

   // half bit-clock period in system cycles, rounded down
   localparam logic [6:0] HALF_128 = 7'(CLK_HZ / (2 * BCLK_128_HZ));
   localparam logic [6:0] HALF_256 = 7'(CLK_HZ / (2 * BCLK_256_HZ));
   localparam logic [6:0] HALF_512 = 7'(CLK_HZ / (2 * BCLK_512_HZ));
   localparam logic [6:0] HALF_1536 = 7'(CLK_HZ / (2 * BCLK_1536_HZ));
   localparam logic [6:0] HALF_2400 = 7'(CLK_HZ / (2 * BCLK_2400_HZ));

   // bit clocks per 8 kHz frame
   localparam logic [8:0] FBITS_128 = 9'(BCLK_128_HZ / FS_HZ);
   localparam logic [8:0] FBITS_256 = 9'(BCLK_256_HZ / FS_HZ);
   localparam logic [8:0] FBITS_512 = 9'(BCLK_512_HZ / FS_HZ);
   localparam logic [8:0] FBITS_1536 = 9'(BCLK_1536_HZ / FS_HZ);
   localparam logic [8:0] FBITS_2400 = 9'(BCLK_2400_HZ / FS_HZ);

   // ****************************************************************
   // framing constants
   // ****************************************************************
   localparam logic [4:0] SYNC_LEN_SHORT = 5'h01; // one bit clock
   localparam logic [4:0] SYNC_LEN_LONG = 5'h08; // eight bit clocks
   localparam logic [4:0] SYNC_LEN_LONG16 = 5'h10; // sixteen bit clocks
   localparam logic [3:0] SLOT8_LAST = 4'h7; // last bit of an 8-clock slot
   localparam logic [3:0] SLOT16_LAST = 4'hF; // last bit of a 16-clock slot
   localparam logic [5:0] FRAME_LAST8 = 6'h1F; // last bit of four 8-clock slots
   localparam logic [5:0] FRAME_LAST16 = 6'h3F; // last bit of four 16-clock slots
   localparam logic [31:0] CFG_RESET = 32'h00000000; // configuration after reset

   // ****************************************************************
   // types
   // ****************************************************************
   typedef enum logic [1:0] {VPP_LFS, VPP_SFS, VPP_GCI} vpp_frame_t;
   typedef enum logic [1:0] {VPP_LIN13, VPP_LIN16, VPP_ULAW, VPP_ALAW} vpp_fmt_t;
   typedef enum logic [1:0] {VPP_PAD_SIGN, VPP_PAD_ZERO, VPP_PAD_ATTEN} vpp_pad_t;

   // configuration word, msb first
   typedef struct packed {
      logic [7:0] rsvd; // 31:24
      logic [3:0] slot_en; // 23:20 one bit per slot
      logic long16; // 19 16-clock long sync
      logic fast_synth_clock_select; // 18 fast synthesis clock
      logic [2:0] rate; // 17:15 master bit clock rate
      logic late_release; // 14 release output on rising edge
      logic sync_gate; // 13 hold frame sync low
      logic mute; // 12 force output low
      logic [2:0] atten; // 11:9 attenuation code
      vpp_pad_t pad; // 8:7 padding mode
      logic little; // 6 little endian bit order
      vpp_fmt_t fmt; // 5:4 sample format
      logic slot16; // 3 16-clock slots
      vpp_frame_t frame; // 2:1 framing format
      logic master; // 0 port master
   } vpp_cfg_t;

   // received sample to the voice link
   typedef struct packed {
      logic [1:0] slot;
      logic [15:0] sample;
   } vpp_rx_t;

endpackage
